// file: rtl/i2c_rtc_if.sv
`timescale 1ns/1ps
interface i2c_rtc_if;

	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// ------------------------------------------------------------------
	// Wired-AND lines with pull-ups
	// ------------------------------------------------------------------
	assign scl = ~(m_scl_oe & ~m_scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

	modport master (
		input  scl,
		input  sda,
		output m_scl_o,
		output m_scl_oe,
		output m_sda_o,
		output m_sda_oe
	);

	modport slave (
		input  scl,
		input  sda,
		output s_sda_o,
		output s_sda_oe
	);

endinterface

// file: rtl/i2c_rtc_master.sv
`timescale 1ns/1ps
module i2c_rtc_master #(
	parameter int HALF_CYC = i2c_rtc_pkg::SCL_HALF_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       ce_i,
	i2c_rtc_if.master       bus,
	input  wire logic       cmd_valid_i,
	output logic            cmd_ready_o,
	input  wire logic       cmd_start_i,
	input  wire logic       cmd_stop_i,
	input  wire logic       cmd_read_i,
	input  wire logic       cmd_last_i,
	input  wire logic       cmd_recover_i,
	input  wire logic [7:0] cmd_data_i,
	output logic            rsp_valid_o,
	output logic [7:0]      rsp_data_o,
	output logic            rsp_ack_o
);

	localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
	localparam logic [CW-1:0] CNT_LOAD = CW'(HALF_CYC - 1);
	// Data changes mid-low so it never moves near a clock edge
	localparam logic [CW-1:0] SDA_SET  = CW'(HALF_CYC / 2);

	if (HALF_CYC < i2c_rtc_pkg::SCL_HALF_MIN)
		$error("HALF_CYC too small for the slave synchronisers");

	typedef struct packed {
		logic                   sda_m;
		logic                   sda_s;
		i2c_rtc_pkg::mst_state_t st;
		logic [CW-1:0]          cnt;
		logic [3:0]             bits;
		logic [7:0]             sh;
		logic                   rd;
		logic                   last;
		logic                   stop;
		logic                   scl_oe;
		logic                   sda_oe;
		logic                   rsp_valid;
		logic [7:0]             rsp_data;
		logic                   rsp_ack;
	} mst_regs_t;

	mst_regs_t q_ff;
	mst_regs_t nxt_q;
	logic      tick;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		nxt_q           = q_ff;
		nxt_q.sda_m     = bus.sda;
		nxt_q.sda_s     = q_ff.sda_m;
		nxt_q.rsp_valid = 1'b0;
		tick            = (q_ff.cnt == '0);
		nxt_q.cnt       = tick ? CNT_LOAD : q_ff.cnt - 1'b1;
		case (q_ff.st)
		i2c_rtc_pkg::M_IDLE:
		begin
			nxt_q.cnt = CNT_LOAD;
			if (cmd_valid_i)
			begin
				nxt_q.rd   = cmd_read_i;
				nxt_q.last = cmd_last_i;
				nxt_q.stop = cmd_stop_i;
				nxt_q.sh   = cmd_data_i;
				nxt_q.bits = '0;
				nxt_q.scl_oe = 1'b1;
				if (cmd_recover_i)
				begin
					nxt_q.sda_oe = 1'b0;
					nxt_q.st     = i2c_rtc_pkg::M_REC_LO;
				end
				else if (cmd_start_i)
				begin
					nxt_q.sda_oe = 1'b0;
					nxt_q.st     = i2c_rtc_pkg::M_RS_LO;
				end
				else
					nxt_q.st = i2c_rtc_pkg::M_BIT_LO;
			end
		end
		i2c_rtc_pkg::M_RS_LO:
			if (tick)
			begin
				nxt_q.scl_oe = 1'b0;
				nxt_q.st     = i2c_rtc_pkg::M_RS_HI;
			end
		i2c_rtc_pkg::M_RS_HI:
			if (tick)
			begin
				nxt_q.sda_oe = 1'b1;
				nxt_q.st     = i2c_rtc_pkg::M_START;
			end
		i2c_rtc_pkg::M_START:
			if (tick)
			begin
				nxt_q.scl_oe = 1'b1;
				nxt_q.st     = i2c_rtc_pkg::M_BIT_LO;
			end
		i2c_rtc_pkg::M_BIT_LO:
		begin
			if (q_ff.cnt == SDA_SET)
			begin
				if (q_ff.bits == i2c_rtc_pkg::ACK_BIT)
					nxt_q.sda_oe = q_ff.rd & ~q_ff.last;
				else
					nxt_q.sda_oe = ~q_ff.rd & ~q_ff.sh[7];
			end
			if (tick)
			begin
				nxt_q.scl_oe = 1'b0;
				nxt_q.st     = i2c_rtc_pkg::M_BIT_HI;
			end
		end
		i2c_rtc_pkg::M_BIT_HI:
			if (tick)
			begin
				nxt_q.scl_oe = 1'b1;
				if (q_ff.bits == i2c_rtc_pkg::ACK_BIT)
				begin
					nxt_q.rsp_valid = 1'b1;
					nxt_q.rsp_data  = q_ff.sh;
					nxt_q.rsp_ack   = ~q_ff.sda_s;
					nxt_q.st        = q_ff.stop ?
						i2c_rtc_pkg::M_STOP_LO : i2c_rtc_pkg::M_IDLE;
				end
				else
				begin
					nxt_q.sh   = {q_ff.sh[6:0], q_ff.sda_s};
					nxt_q.bits = q_ff.bits + 1'b1;
					nxt_q.st   = i2c_rtc_pkg::M_BIT_LO;
				end
			end
		i2c_rtc_pkg::M_STOP_LO:
		begin
			if (q_ff.cnt == SDA_SET)
				nxt_q.sda_oe = 1'b1;
			if (tick)
			begin
				nxt_q.scl_oe = 1'b0;
				nxt_q.st     = i2c_rtc_pkg::M_STOP_HI;
			end
		end
		i2c_rtc_pkg::M_STOP_HI:
			if (tick)
			begin
				nxt_q.sda_oe = 1'b0;
				nxt_q.st     = i2c_rtc_pkg::M_STOP_END;
			end
		i2c_rtc_pkg::M_STOP_END:
			if (tick)
				nxt_q.st = i2c_rtc_pkg::M_IDLE;
		i2c_rtc_pkg::M_REC_LO:
			if (tick)
			begin
				nxt_q.scl_oe = 1'b0;
				nxt_q.st     = i2c_rtc_pkg::M_REC_HI;
			end
		i2c_rtc_pkg::M_REC_HI:
			if (tick)
			begin
				nxt_q.scl_oe = 1'b1;
				nxt_q.bits   = q_ff.bits + 1'b1;
				if (q_ff.bits + 1'b1 == i2c_rtc_pkg::REC_CLOCKS)
					nxt_q.st = i2c_rtc_pkg::M_STOP_LO;
				else
					nxt_q.st = i2c_rtc_pkg::M_REC_LO;
			end
		default:
			nxt_q.st = i2c_rtc_pkg::M_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			q_ff <= '0;
		else if (ce_i)
			q_ff <= nxt_q;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign cmd_ready_o  = ce_i & (q_ff.st == i2c_rtc_pkg::M_IDLE);
	assign rsp_valid_o  = q_ff.rsp_valid;
	assign rsp_data_o   = q_ff.rsp_data;
	assign rsp_ack_o    = q_ff.rsp_ack;
	assign bus.m_scl_o  = 1'b0;
	assign bus.m_scl_oe = q_ff.scl_oe;
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_sda_oe = q_ff.sda_oe;

endmodule // i2c_rtc_master

// file: rtl/i2c_rtc_pkg.sv
package i2c_rtc_pkg;

	// ------------------------------------------------------------------
	// Protocol constants
	// ------------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR = 7'h51;
	localparam int         PTR_W      = 5;
	localparam logic [3:0] ACK_BIT    = 4'h8;
	localparam logic [3:0] REC_CLOCKS = 4'h9;

	// ------------------------------------------------------------------
	// Timing of the generated serial clock
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int SCL_HALF_NS   = 24;
	localparam int SCL_HALF_CYC  =
		(SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCL_HALF_MIN  = 4;

	// ------------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE    = 3'h0,
		S_ADDR    = 3'h1,
		S_ADDR_AK = 3'h2,
		S_RX      = 3'h3,
		S_RX_AK   = 3'h4,
		S_TX      = 3'h5,
		S_TX_AK   = 3'h6,
		S_IGNORE  = 3'h7
	} slv_state_t;

	typedef enum logic [3:0] {
		M_IDLE     = 4'h0,
		M_RS_LO    = 4'h1,
		M_RS_HI    = 4'h2,
		M_START    = 4'h3,
		M_BIT_LO   = 4'h4,
		M_BIT_HI   = 4'h5,
		M_STOP_LO  = 4'h6,
		M_STOP_HI  = 4'h7,
		M_STOP_END = 4'h8,
		M_REC_LO   = 4'h9,
		M_REC_HI   = 4'hA
	} mst_state_t;

endpackage

// file: rtl/i2c_rtc_slave.sv
`timescale 1ns/1ps
module i2c_rtc_slave #(
	parameter int PW = i2c_rtc_pkg::PTR_W
) (
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	input  wire logic          ce_i,
	i2c_rtc_if.slave           bus,
	output logic               wr_valid_o,
	output logic [PW-1:0]      wr_addr_o,
	output logic [7:0]         wr_data_o,
	output logic [PW-1:0]      rd_addr_o,
	input  wire logic [7:0]    rd_data_i,
	output logic               rd_strobe_o,
	output logic               busy_o
);

	if (PW < 1 || PW > 8)
		$error("PW must lie between 1 and 8");

	typedef struct packed {
		logic                    scl_m;
		logic                    scl_s;
		logic                    scl_p;
		logic                    sda_m;
		logic                    sda_s;
		logic                    sda_p;
		i2c_rtc_pkg::slv_state_t st;
		logic [3:0]              bits;
		logic [7:0]              sh;
		logic [PW-1:0]           ptr;
		logic                    rw;
		logic                    ptr_phase;
		logic                    mack;
		logic                    sda_oe;
		logic                    wr_valid;
		logic [PW-1:0]           wr_addr;
		logic [7:0]              wr_data;
		logic                    rd_strobe;
	} slv_regs_t;

	slv_regs_t q_ff;
	slv_regs_t nxt_q;
	logic      rise;
	logic      fall;
	logic      start_cond;
	logic      stop_cond;
	logic      byte_done;

	// ------------------------------------------------------------------
	// Line events, taken only from the second and third flops
	// ------------------------------------------------------------------
	assign rise       = q_ff.scl_s & ~q_ff.scl_p;
	assign fall       = ~q_ff.scl_s & q_ff.scl_p;
	assign start_cond = q_ff.scl_s & q_ff.scl_p & q_ff.sda_p & ~q_ff.sda_s;
	assign stop_cond  = q_ff.scl_s & q_ff.scl_p & ~q_ff.sda_p & q_ff.sda_s;
	assign byte_done  = fall & (q_ff.bits == i2c_rtc_pkg::ACK_BIT);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		nxt_q           = q_ff;
		nxt_q.scl_m     = bus.scl;
		nxt_q.scl_s     = q_ff.scl_m;
		nxt_q.scl_p     = q_ff.scl_s;
		nxt_q.sda_m     = bus.sda;
		nxt_q.sda_s     = q_ff.sda_m;
		nxt_q.sda_p     = q_ff.sda_s;
		nxt_q.wr_valid  = 1'b0;
		nxt_q.rd_strobe = 1'b0;
		if (start_cond)
		begin
			// A repeated START also closes a write in progress
			nxt_q.st     = i2c_rtc_pkg::S_ADDR;
			nxt_q.bits   = '0;
			nxt_q.sda_oe = 1'b0;
		end
		else if (stop_cond)
		begin
			nxt_q.st     = i2c_rtc_pkg::S_IDLE;
			nxt_q.sda_oe = 1'b0;
		end
		else
		begin
			case (q_ff.st)
			i2c_rtc_pkg::S_IDLE:
				nxt_q.sda_oe = 1'b0;
			i2c_rtc_pkg::S_ADDR:
			begin
				if (rise)
				begin
					nxt_q.sh   = {q_ff.sh[6:0], q_ff.sda_s};
					nxt_q.bits = q_ff.bits + 1'b1;
				end
				if (byte_done)
				begin
					if (q_ff.sh[7:1] == i2c_rtc_pkg::SLAVE_ADDR)
					begin
						nxt_q.rw     = q_ff.sh[0];
						nxt_q.sda_oe = 1'b1;
						nxt_q.st     = i2c_rtc_pkg::S_ADDR_AK;
					end
					else
						nxt_q.st = i2c_rtc_pkg::S_IGNORE;
				end
			end
			i2c_rtc_pkg::S_ADDR_AK:
				// Low is held until the falling edge that ends the ninth pulse
				if (fall)
				begin
					nxt_q.bits = '0;
					if (q_ff.rw)
					begin
						nxt_q.sh        = rd_data_i;
						nxt_q.sda_oe    = ~rd_data_i[7];
						nxt_q.rd_strobe = 1'b1;
						nxt_q.st        = i2c_rtc_pkg::S_TX;
					end
					else
					begin
						nxt_q.sda_oe    = 1'b0;
						nxt_q.ptr_phase = 1'b1;
						nxt_q.st        = i2c_rtc_pkg::S_RX;
					end
				end
			i2c_rtc_pkg::S_RX:
			begin
				if (rise)
				begin
					nxt_q.sh   = {q_ff.sh[6:0], q_ff.sda_s};
					nxt_q.bits = q_ff.bits + 1'b1;
				end
				if (byte_done)
				begin
					nxt_q.sda_oe = 1'b1;
					nxt_q.st     = i2c_rtc_pkg::S_RX_AK;
					if (q_ff.ptr_phase)
					begin
						nxt_q.ptr       = q_ff.sh[PW-1:0];
						nxt_q.ptr_phase = 1'b0;
					end
					else
					begin
						nxt_q.wr_valid = 1'b1;
						nxt_q.wr_addr  = q_ff.ptr;
						nxt_q.wr_data  = q_ff.sh;
						nxt_q.ptr      = q_ff.ptr + 1'b1;
					end
				end
			end
			i2c_rtc_pkg::S_RX_AK:
				if (fall)
				begin
					nxt_q.sda_oe = 1'b0;
					nxt_q.bits   = '0;
					nxt_q.st     = i2c_rtc_pkg::S_RX;
				end
			i2c_rtc_pkg::S_TX:
			begin
				if (rise)
					nxt_q.bits = q_ff.bits + 1'b1;
				if (byte_done)
				begin
					nxt_q.sda_oe = 1'b0;
					nxt_q.ptr    = q_ff.ptr + 1'b1;
					nxt_q.st     = i2c_rtc_pkg::S_TX_AK;
				end
				else if (fall)
				begin
					nxt_q.sh     = {q_ff.sh[6:0], 1'b0};
					nxt_q.sda_oe = ~q_ff.sh[6];
				end
			end
			i2c_rtc_pkg::S_TX_AK:
			begin
				if (rise)
					nxt_q.mack = ~q_ff.sda_s;
				if (fall)
				begin
					nxt_q.bits = '0;
					if (q_ff.mack)
					begin
						nxt_q.sh        = rd_data_i;
						nxt_q.sda_oe    = ~rd_data_i[7];
						nxt_q.rd_strobe = 1'b1;
						nxt_q.st        = i2c_rtc_pkg::S_TX;
					end
					else
					begin
						// Line stays released so the master can issue STOP
						nxt_q.sda_oe = 1'b0;
						nxt_q.st     = i2c_rtc_pkg::S_IGNORE;
					end
				end
			end
			i2c_rtc_pkg::S_IGNORE:
			begin
				// Recovery clocks land here once the byte has run out;
				// a released data line under a high clock counts as STOP
				nxt_q.sda_oe = 1'b0;
				if (rise && q_ff.sda_s)
					nxt_q.st = i2c_rtc_pkg::S_IDLE;
			end
			default:
			begin
				nxt_q.sda_oe = 1'b0;
				nxt_q.st     = i2c_rtc_pkg::S_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			q_ff <= '0;
		else if (ce_i)
			q_ff <= nxt_q;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Read data is taken combinationally at the load edge, so the user
	// store must answer rd_addr_o in the same cycle
	assign wr_valid_o   = q_ff.wr_valid;
	assign wr_addr_o    = q_ff.wr_addr;
	assign wr_data_o    = q_ff.wr_data;
	assign rd_addr_o    = q_ff.ptr;
	assign rd_strobe_o  = q_ff.rd_strobe;
	assign busy_o       = (q_ff.st != i2c_rtc_pkg::S_IDLE) &&
	                      (q_ff.st != i2c_rtc_pkg::S_IGNORE);
	assign bus.s_sda_o  = 1'b0;
	assign bus.s_sda_oe = q_ff.sda_oe;

endmodule // i2c_rtc_slave

// file: sim/i2c_rtc_chk.sv
`timescale 1ns/1ps
module i2c_rtc_chk #(
	parameter int HALF = 6
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic s_sda_oe
);
	// ------------------------------------------------------------------
	// Bus tracker
	// ------------------------------------------------------------------
	logic       scl_q, sda_q, act, dat, rd, match, nack;
	logic [3:0] bitn;
	logic [7:0] sh;
	wire        ack9 = scl && !scl_q && act && bitn == 4'h8;

	// Counts every clock rise between START and STOP, so it stays in step through recovery
	always_ff @(posedge clk_i)
	begin
		scl_q <= scl;
		sda_q <= sda;
		if (!nrst_i || (scl && scl_q && sda_q != sda))
		begin
			act  <= nrst_i && !sda;
			nack <= 1'b0;
			dat  <= 1'b0;
			bitn <= 4'h0;
		end
		else if (ack9)
		begin
			bitn <= 4'h0;
			dat  <= 1'b1;
			nack <= nack || (dat && rd && sda);
			if (!dat)
			begin
				match <= sh[7:1] == i2c_rtc_pkg::SLAVE_ADDR;
				rd    <= sh[0];
			end
		end
		else if (scl && !scl_q && act)
		begin
			bitn <= bitn + 4'h1;
			sh   <= {sh[6:0], sda};
		end
	end

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence start_s; scl && scl_q && sda_q && !sda; endsequence
	sequence stop_s; scl && scl_q && !sda_q && sda; endsequence

	slv_hold_a: assert property (scl && scl_q |-> $stable(s_sda_oe))
		else $error("slave drive changed while clock high");
	slv_lag_a: assert property ($changed(s_sda_oe) |->
		!$past(scl) && $past(scl, HALF))
		else $error("slave drive changed away from a clock fall");
	addr_ack_a: assert property (ack9 && !dat &&
		sh[7:1] == i2c_rtc_pkg::SLAVE_ADDR |-> !sda)
		else $error("own address not acknowledged");
	foreign_nak_a: assert property (ack9 && !dat &&
		sh[7:1] != i2c_rtc_pkg::SLAVE_ADDR |-> sda)
		else $error("foreign address acknowledged");
	wr_ack_a: assert property (ack9 && dat && match && !rd |-> !sda)
		else $error("written byte not acknowledged");
	rd_release_a: assert property (ack9 && dat && match && rd |->
		!s_sda_oe)
		else $error("slave drives the master acknowledge");
	nack_quiet_a: assert property (nack |-> !s_sda_oe)
		else $error("slave drives after no-acknowledge");
	foreign_quiet_a: assert property (act && dat && !match |->
		!s_sda_oe)
		else $error("unaddressed slave drives data");
	start_scl_a: assert property (start_s |-> ##[1:8] !scl)
		else $error("clock not lowered after start");
	stop_idle_a: assert property (stop_s |=> (scl && sda)[*4])
		else $error("bus not idle after stop");
endmodule // i2c_rtc_chk

// file: sim/tb_rtc_i2c_slave_port.sv
`timescale 1ns/1ps
module tb_rtc_i2c_slave_port;
	localparam logic [4:0] ST  = 5'h10;
	localparam logic [4:0] SP  = 5'h08;
	localparam logic [4:0] RD  = 5'h04;
	localparam logic [4:0] LA  = 5'h02;
	localparam logic [4:0] RC  = 5'h01;
	localparam logic [7:0] ADW = {i2c_rtc_pkg::SLAVE_ADDR, 1'b0};
	localparam logic [7:0] ADR = {i2c_rtc_pkg::SLAVE_ADDR, 1'b1};
	logic        clk, nrst, nrst_m, ce, cmd_valid, cmd_ready, rsp_ack;
	logic        wr_valid, busy, rsp_valid, rd_strobe;
	logic [4:0]  cmd_f, wr_addr, rd_addr;
	logic [7:0]  cmd_data, rsp_data, wr_data;
	logic [7:0]  mem [32];
	logic [12:0] wq [$];
	logic [7:0]  wd [4] = '{8'hFE, 8'hA5, 8'h3C, 8'h5A};
	logic [6:0]  fa [2] = '{7'h50, 7'h11};
	logic [12:0] ew [3] = '{13'h1EA5, 13'h1F3C, 13'h005A};
	int          fails, n_tests;
	int          n_rsp, n_rds;

	i2c_rtc_if bus ();
	i2c_rtc_master #(.HALF_CYC(6)) i_i2c_rtc_master (.clk_i(clk),
		.nrst_i(nrst_m), .ce_i(ce), .bus(bus), .cmd_valid_i(cmd_valid),
		.cmd_ready_o(cmd_ready), .cmd_start_i(cmd_f[4]),
		.cmd_stop_i(cmd_f[3]), .cmd_read_i(cmd_f[2]), .cmd_last_i(cmd_f[1]),
		.cmd_recover_i(cmd_f[0]), .cmd_data_i(cmd_data),
		.rsp_valid_o(rsp_valid),
		.rsp_data_o(rsp_data), .rsp_ack_o(rsp_ack));
	i2c_rtc_slave i_i2c_rtc_slave (.clk_i(clk), .nrst_i(nrst), .ce_i(ce),
		.bus(bus), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr),
		.wr_data_o(wr_data), .rd_addr_o(rd_addr), .rd_data_i(mem[rd_addr]),
		.rd_strobe_o(rd_strobe), .busy_o(busy));
	i2c_rtc_chk #(.HALF(6)) i_i2c_rtc_chk (.clk_i(clk), .nrst_i(nrst),
		.scl(bus.scl), .sda(bus.sda), .s_sda_oe(bus.s_sda_oe));

	// ------------------------------------------------------------------
	// Register file behind the slave
	// ------------------------------------------------------------------
	always @(posedge clk)
		if (wr_valid === 1'b1)
		begin
			mem[wr_addr] <= wr_data;
			wq.push_back({wr_addr, wr_data});
		end

	// Pulses are counted so that every one-cycle output gets compared
	always @(posedge clk)
	begin
		if (rsp_valid === 1'b1)
			n_rsp <= n_rsp + 1;
		if (rd_strobe === 1'b1)
			n_rds <= n_rds + 1;
	end

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task chk(input string nm, input logic [12:0] s, input logic [12:0] e);
		n_tests++;
		if (s !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Holds the command until the edge that takes it
	task give(input logic [4:0] f, input logic [7:0] d);
		int n;
		n = 0;
		cmd_f = f;
		cmd_data = d;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && n < 400)
		begin
			step(1);
			n++;
		end
		if (n >= 400)
			fails++;
		step(1);
		cmd_valid = 1'b0;
	endtask

	task xfer(input logic [4:0] f, input logic [7:0] d);
		int n;
		n = 0;
		give(f, d);
		while (cmd_ready !== 1'b1 && n < 600)
		begin
			step(1);
			n++;
		end
		if (n >= 600)
			fails++;
	endtask

	task end_of_test;
		$display("Checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		#80000;
		fails++;
		end_of_test;
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial
	begin
		mem = '{default: 8'h00};
		{nrst, nrst_m, cmd_valid, cmd_f, cmd_data} = '0;
		ce = 1'b1;
		fails = 0;
		n_tests = 0;
		step(20);
		nrst = 1'b1;
		nrst_m = 1'b1;
		step(4);
		xfer(ST, ADW);
		chk("addr ack", rsp_ack, 1'b1);
		chk("busy", busy, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			xfer(i == 3 ? SP : 5'h00, wd[i]);
			chk("data ack", rsp_ack, 1'b1);
			chk("echo", rsp_data, wd[i]);
		end
		for (int i = 0; i < 3; i++)
			chk("write", wq[i], ew[i]);
		xfer(ST, ADW);
		xfer(5'h00, 8'h1E);
		xfer(ST, ADR);
		chk("read ack", rsp_ack, 1'b1);
		for (int i = 1; i < 4; i++)
		begin
			xfer(i == 3 ? (SP | RD | LA) : RD, 8'h00);
			chk("read", rsp_data, wd[i]);
		end
		chk("released", bus.sda, 1'b1);
		foreach (fa[i])
		begin
			xfer(ST, {fa[i], 1'b0});
			chk("foreign ack", rsp_ack, 1'b0);
			xfer(SP, 8'h77);
		end
		chk("write count", 13'(wq.size()), 13'h3);
		// Master reset in a high phase leaves a zero bit on the line
		xfer(ST, ADW);
		xfer(SP, 8'h04);
		xfer(ST, ADR);
		give(RD, 8'h00);
		step(45);
		nrst_m = 1'b0;
		step(3);
		nrst_m = 1'b1;
		chk("stuck", bus.sda, 1'b0);
		xfer(RC, 8'h00);
		chk("freed", bus.sda, 1'b1);
		chk("idle", busy, 1'b0);
		xfer(ST, ADW);
		xfer(SP, 8'h00);
		xfer(ST, ADR);
		xfer(SP | RD | LA, 8'h00);
		chk("after", rsp_data, 8'h5A);
		chk("responses", 13'(n_rsp), 13'h0016);
		chk("read loads", 13'(n_rds), 13'h0005);
		end_of_test;
	end
endmodule // tb_rtc_i2c_slave_port
